// ---- src/fhc_ctrl.sv ----
// host controller driving a paged flash through its strobe pins
`timescale 1ns/1ns
module fhc_ctrl #(
  parameter bit X16 = 1'b0,
  parameter int RD_DEPTH = fhc_pkg::RD_FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // request port
  input wire fhc_pkg::fhc_req_t req,
  input wire logic req_valid,
  output logic req_ready,
  // permission for program and erase
  input wire logic wp_release,
  // read data stream
  output fhc_pkg::fhc_word_t rd_data,
  output logic rd_valid,
  input wire logic rd_ready,
  // status
  output logic recovered,
  output logic flash_busy,
  // strobe pins
  output fhc_pkg::fhc_pins_t pins,
  input wire logic busy_n_od,
  // multiplexed lanes, low byte
  input wire logic [7:0] io_low_byte_i,
  output logic [7:0] io_low_byte_o,
  output logic io_low_byte_oe_n,
  // multiplexed lanes, high byte
  input wire logic [7:0] io_high_byte_i,
  output logic [7:0] io_high_byte_o,
  output logic io_high_byte_oe_n
);
  import fhc_pkg::*;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (RECOVER_CYC >= (1 << CNT_W)) begin : g_bad_cnt
    $error("recovery count does not fit the counter");
  end
  if (RD_DEPTH < 2) begin : g_bad_depth
    $error("read fifo needs at least two words");
  end

  // ----------------------------------------------------------------
  // state machine types and registers
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_PWR = 7'h01,
    ST_IDLE = 7'h02,
    ST_WLOW = 7'h04,
    ST_WHIGH = 7'h08,
    ST_RLOW = 7'h10,
    ST_RHIGH = 7'h20,
    ST_WAIT = 7'h40
  } fhc_state_t;

  fhc_state_t state_q;
  fhc_state_t state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  fhc_pins_t pins_q;
  fhc_pins_t pins_d;
  logic [7:0] lo_q;
  logic [7:0] lo_d;
  logic [7:0] hi_q;
  logic [7:0] hi_d;
  logic lo_oe_n_q;
  logic lo_oe_n_d;
  logic hi_oe_n_q;
  logic hi_oe_n_d;
  logic rec_q;
  logic rec_d;
  logic fifo_in_ready;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire cnt_done = (cnt_q == '0);
  wire is_read = (req.op == FHC_OP_RDATA);
  // a read is refused while the fifo has no room, so no word is lost
  wire take = (state_q == ST_IDLE) && req_valid && (!is_read || fifo_in_ready);
  wire push = (state_q == ST_RLOW) && cnt_done;
  wire [7:0] hi_in = X16 ? io_high_byte_i : 8'h00;
  wire ready_line = busy_n_od;

  assign req_ready = (state_q == ST_IDLE) && (!is_read || fifo_in_ready);
  assign recovered = rec_q;
  assign flash_busy = !busy_n_od;
  assign pins = pins_q;
  assign io_low_byte_o = lo_q;
  assign io_high_byte_o = hi_q;
  assign io_low_byte_oe_n = lo_oe_n_q;
  assign io_high_byte_oe_n = hi_oe_n_q;

  // ----------------------------------------------------------------
  // next state and pin values
  // ----------------------------------------------------------------
  // pins are registered so strobes and lanes never glitch
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_done ? cnt_q : cnt_q - CNT_W'(1);
    pins_d = pins_q;
    lo_d = lo_q;
    hi_d = hi_q;
    lo_oe_n_d = lo_oe_n_q;
    hi_oe_n_d = hi_oe_n_q;
    rec_d = rec_q;
    // protect unless recovered and software allows it
    pins_d.wp_n = rec_q && wp_release;
    unique case (state_q)
      ST_PWR: begin
        pins_d.we_n = 1'b1;
        if (cnt_done) begin
          rec_d = 1'b1;
          state_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        pins_d.cmd_latch_sel = 1'b0;
        pins_d.addr_latch_sel = 1'b0;
        lo_oe_n_d = 1'b1;
        hi_oe_n_d = 1'b1;
        pins_d.ce_n = !req_valid;
        if (take) begin
          pins_d.ce_n = 1'b0;
          pins_d.re_n = 1'b1;
          pins_d.we_n = 1'b1;
          // at most one latch select per op, none for data reads and writes
          pins_d.cmd_latch_sel = (req.op == FHC_OP_CMD);
          pins_d.addr_latch_sel = (req.op == FHC_OP_ADDR);
          lo_d = req.data[7:0];
          hi_d = X16 ? req.data[15:8] : 8'h00;
          lo_oe_n_d = is_read;
          // high byte only for data writes
          hi_oe_n_d = !(X16 && req.op == FHC_OP_WDATA);
          if (req.wait_rdy) begin
            state_d = ST_WAIT;
          end else if (is_read) begin
            state_d = ST_RLOW;
            cnt_d = CNT_W'(RE_LOW_CYC);
          end else begin
            state_d = ST_WLOW;
            cnt_d = CNT_W'(WE_LOW_CYC);
          end
        end
      end
      ST_WAIT: begin
        // held selected; low on the shared line means some device busy
        lo_oe_n_d = 1'b1;
        hi_oe_n_d = 1'b1;
        pins_d.cmd_latch_sel = 1'b0;
        pins_d.addr_latch_sel = 1'b0;
        if (ready_line) begin
          state_d = ST_IDLE;
        end
      end
      ST_WLOW: begin
        pins_d.we_n = 1'b0;
        if (cnt_done) begin
          // rising write strobe is where the device latches the lanes
          pins_d.we_n = 1'b1;
          state_d = ST_WHIGH;
          cnt_d = CNT_W'(WE_HIGH_CYC - 1);
        end
      end
      ST_WHIGH: begin
        if (cnt_done) begin
          state_d = ST_IDLE;
        end
      end
      ST_RLOW: begin
        // lanes released so the device may drive them
        pins_d.re_n = 1'b0;
        if (cnt_done) begin
          pins_d.re_n = 1'b1;
          state_d = ST_RHIGH;
          cnt_d = CNT_W'(RE_HIGH_CYC - 1);
        end
      end
      ST_RHIGH: begin
        if (cnt_done) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_PWR;
        cnt_d = CNT_W'(RECOVER_CYC - 1);
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // recovery starts counting at reset release
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_PWR;
      cnt_q <= CNT_W'(RECOVER_CYC - 1);
      rec_q <= 1'b0;
      pins_q <= PINS_RESET;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      rec_q <= rec_d;
      pins_q <= pins_d;
    end
  end

  // lane drivers stay released after reset
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lo_q <= 8'h00;
      hi_q <= 8'h00;
      lo_oe_n_q <= 1'b1;
      hi_oe_n_q <= 1'b1;
    end else begin
      lo_q <= lo_d;
      hi_q <= hi_d;
      lo_oe_n_q <= lo_oe_n_d;
      hi_oe_n_q <= hi_oe_n_d;
    end
  end

  // ----------------------------------------------------------------
  // read data buffer
  // ----------------------------------------------------------------
  // sampled at the end of the low phase, just before the read strobe rises
  fhc_fifo #(
    .WIDTH(16),
    .DEPTH(RD_DEPTH)
  ) u_rd_fifo (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .in_data({hi_in, io_low_byte_i}),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .out_data(rd_data),
    .out_valid(rd_valid),
    .out_ready(rd_ready)
  );
endmodule

// ---- src/fhc_pkg.sv ----
// shared constants, types and timing for the flash host controller
package fhc_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_RECOVER_NS = 10000;     // power transition recovery, minimum
  localparam int T_WE_LOW_NS = 25;         // write strobe low width, plain default
  localparam int T_WE_HIGH_NS = 15;        // write strobe high hold, plain default
  localparam int T_RE_LOW_NS = 25;         // read strobe low width, plain default
  localparam int T_RE_HIGH_NS = 15;        // read strobe high width, plain default

  // minimum times round up, never below one cycle
  function automatic int fhc_min_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int RECOVER_CYC = fhc_min_cyc(T_RECOVER_NS);
  localparam int WE_LOW_CYC = fhc_min_cyc(T_WE_LOW_NS);
  localparam int WE_HIGH_CYC = fhc_min_cyc(T_WE_HIGH_NS);
  localparam int RE_LOW_CYC = fhc_min_cyc(T_RE_LOW_NS);
  localparam int RE_HIGH_CYC = fhc_min_cyc(T_RE_HIGH_NS);
  localparam int CNT_W = 12;

  // ----------------------------------------------------------------
  // array geometry of the attached device
  // ----------------------------------------------------------------
  localparam int PAGES_PER_BLOCK = 64;
  localparam int PAGE_MAIN_X8 = 2048;
  localparam int PAGE_SPARE_X8 = 64;
  localparam int PAGE_MAIN_X16 = 1024;
  localparam int PAGE_SPARE_X16 = 32;
  localparam int ADDR_CYCLES_SMALL = 4;
  localparam int ADDR_CYCLES_LARGE = 5;
  localparam int RD_FIFO_DEPTH = 4;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef logic [15:0] fhc_word_t;

  typedef enum logic [1:0] {
    FHC_OP_CMD = 2'h0,
    FHC_OP_ADDR = 2'h1,
    FHC_OP_WDATA = 2'h2,
    FHC_OP_RDATA = 2'h3
  } fhc_op_t;

  typedef struct packed {
    logic wait_rdy;    // hold until ready/busy line reads high
    fhc_op_t op;
    fhc_word_t data;
  } fhc_req_t;

  typedef struct packed {
    logic ce_n;
    logic cmd_latch_sel;
    logic addr_latch_sel;
    logic we_n;
    logic re_n;
    logic wp_n;
  } fhc_pins_t;

  localparam fhc_pins_t PINS_RESET = '{ce_n: 1'b1, cmd_latch_sel: 1'b0, addr_latch_sel: 1'b0,
                                       we_n: 1'b1, re_n: 1'b1, wp_n: 1'b0};

endpackage

// ---- src/fhc_fifo.sv ----
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ns
module fhc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // fill side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // drain side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("fifo depth must be a power of two, at least 2");
  end

  // ----------------------------------------------------------------
  // storage and pointers
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  // extra pointer bit tells full from empty
  assign in_ready = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
  assign out_valid = (wr_q != rd_q);
  assign out_data = mem_q[rd_q[AW-1:0]];

  // pointers
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_q + (AW+1)'(push);
      rd_q <= rd_q + (AW+1)'(pop);
    end
  end

  // data array needs no reset; valid bits come from the pointers
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end
endmodule

// ---- testbench/fhc_ctrl_monitor.sv ----
// assertion checker bound to the flash host controller
`timescale 1ns/1ns
module fhc_ctrl_chk (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // request and status
  input wire logic req_ready,
  input wire logic recovered,
  input wire logic wp_release,
  input wire logic flash_busy,
  input wire logic busy_n_od,
  input wire logic rd_valid,
  // strobes and lanes
  input wire fhc_pkg::fhc_pins_t pins,
  input wire logic [7:0] io_low_byte_o,
  input wire logic io_low_byte_oe_n
);
  import fhc_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // write strobe stays low seven cycles, then rises
  sequence we_pulse_s;
    !pins.we_n [*7] ##1 pins.we_n;
  endsequence
  // read setup: selected, no latch select, host lanes released
  sequence rd_setup_s;
    !pins.ce_n && pins.we_n && !pins.cmd_latch_sel && !pins.addr_latch_sel && io_low_byte_oe_n;
  endsequence
  sel_excl_a: assert property (!(pins.cmd_latch_sel && pins.addr_latch_sel))
    else $error("both latch selects high");
  rec_quiet_a: assert property (!recovered |-> pins.we_n && !pins.wp_n && !req_ready)
    else $error("activity during recovery");
  we_width_a: assert property ($fell(pins.we_n) |-> we_pulse_s)
    else $error("write strobe width wrong");
  we_setup_a: assert property (!pins.we_n |-> !pins.ce_n && pins.re_n && !io_low_byte_oe_n
    && $stable(io_low_byte_o) && $stable(pins.cmd_latch_sel)) else $error("lanes moved under strobe");
  rd_setup_a: assert property (!pins.re_n |-> rd_setup_s)
    else $error("read strobe without read setup");
  busy_map_a: assert property (flash_busy == !busy_n_od)
    else $error("busy flag not the ready line");
  wp_gate_a: assert property (!wp_release |=> !pins.wp_n)
    else $error("protect released without permission");
  wp_on_a: assert property (recovered && wp_release |=> pins.wp_n)
    else $error("protect not released");
  rd_push_a: assert property ($rose(pins.re_n) |-> ##[0:3] rd_valid)
    else $error("read word not queued");
endmodule
bind fhc_ctrl fhc_ctrl_chk chk_u (.clk_sys, .arst_n, .req_ready, .recovered, .wp_release, .flash_busy,
  .busy_n_od, .rd_valid, .pins, .io_low_byte_o, .io_low_byte_oe_n);

// ---- testbench/fhc_dev_model.sv ----
// behavioural paged flash device facing the host controller
`timescale 1ns/1ns
module fhc_dev_model #(
  parameter bit X16 = 1'b0,
  parameter logic [7:0] OP_CMD = 8'h10,
  parameter int BUSY_NS = 400
) (
  // strobes from the host
  input wire fhc_pkg::fhc_pins_t pins,
  // resolved lanes and device drive
  input wire logic [7:0] lane,
  output logic [7:0] dev_o,
  output logic dev_oe,
  // 1 = pulling the shared ready line low
  output logic busy,
  // last latched cycle, for the bench
  output logic [1:0] cap_kind,
  output logic [7:0] cap_val,
  output int cap_cnt
);
  import fhc_pkg::*;
  // one page of a block of PAGES_PER_BLOCK pages: main area, then spare
  localparam int MAIN_LEN = X16 ? PAGE_MAIN_X16 : PAGE_MAIN_X8;
  localparam int PAGE_LEN = X16 ? PAGE_MAIN_X16 + PAGE_SPARE_X16 : PAGE_MAIN_X8 + PAGE_SPARE_X8;
  logic [11:0] col;
  initial begin
    busy = 1'b0;
    col = '0;
    cap_cnt = 0;
  end
  // latch on strobe rise, only while selected
  always @(posedge pins.we_n) begin
    if (!pins.ce_n) begin
      cap_kind = pins.addr_latch_sel ? 2'h1 : pins.cmd_latch_sel ? 2'h0 : 2'h2;
      cap_val = lane;
      cap_cnt++;
      if (pins.cmd_latch_sel)
        col = '0;
      // start refused while protected; array untouched
      if (pins.cmd_latch_sel && lane == OP_CMD && pins.wp_n)
        busy = 1'b1;
    end
  end
  // stays busy for BUSY_NS, whatever the select does
  always @(posedge busy) #BUSY_NS busy = 1'b0;
  // each read fall gives the next column
  always @(negedge pins.re_n) begin
    if (!pins.ce_n) begin
      // every block valid: first spare word keeps the erased good-block mark
      dev_o = (col == 12'(MAIN_LEN)) ? 8'hff : col[7:0];
      // column wraps at the end of the spare area
      col = (col == 12'(PAGE_LEN - 1)) ? 12'h000 : col + 12'h001;
    end
  end
  assign dev_oe = !pins.ce_n && !pins.re_n;
endmodule

// ---- testbench/flash_memory_pin_interface_test.sv ----
// self-checking bench for the flash host controller
`timescale 1ns/1ns
module flash_memory_pin_interface_test;
  import fhc_pkg::*;
  localparam logic [7:0] OP_CMD = 8'h10;
  logic clk_sys, arst_n, req_valid, req_ready, wp_release, rd_valid, rd_ready;
  logic recovered, flash_busy, busy_n_od, io_low_byte_oe_n, dev_oe, busy, hi_oe_n;
  fhc_req_t req;
  fhc_word_t rd_data;
  fhc_pins_t pins;
  logic [7:0] io_low_byte_o, lane, dev_o, cap_val, v, hi_o;
  logic [1:0] cap_kind;
  int cap_cnt, bad_count, n_tests, seed, i, k, r, ncap, nrd;
  fhc_ctrl #(.X16(1'b0), .RD_DEPTH(RD_FIFO_DEPTH)) dut_u (.clk_sys, .arst_n, .req, .req_valid, .req_ready,
    .wp_release, .rd_data, .rd_valid, .rd_ready, .recovered, .flash_busy, .pins, .busy_n_od,
    .io_low_byte_i(lane), .io_low_byte_o, .io_low_byte_oe_n, .io_high_byte_i(8'h00),
    .io_high_byte_o(hi_o), .io_high_byte_oe_n(hi_oe_n));
  fhc_dev_model #(.OP_CMD(OP_CMD)) dev_u (.pins, .lane, .dev_o, .dev_oe, .busy, .cap_kind, .cap_val,
    .cap_cnt);
  assign busy_n_od = ~busy;
  // released lanes float: show the inverse, not a stale value
  always @(io_low_byte_oe_n, io_low_byte_o, dev_oe, dev_o) begin
    if (!io_low_byte_oe_n)
      lane = io_low_byte_o;
    else if (dev_oe)
      lane = dev_o;
    else
      lane = ~lane;
  end
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  function automatic logic [1:0] kind_of(input fhc_op_t op);
    return op == FHC_OP_CMD ? 2'h0 : op == FHC_OP_ADDR ? 2'h1 : 2'h2;
  endfunction
  function automatic fhc_word_t exp_word(input int w);
    return {8'h00, w[7:0]};
  endfunction
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    n_tests++;
    if (!ok) begin
      bad_count++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  task automatic hang;
    chk(1'b0, "wait limit ran out");
    test_done;
  endtask
  // offer, hold until taken, then for plain writes check what the device latched
  task automatic send(input logic w, input fhc_op_t op, input fhc_word_t d);
    int t;
    req = '{w, op, d};
    req_valid = 1'b1;
    for (t = 0; t < 3000; t++) begin
      #1;
      if (req_ready === 1'b1)
        break;
      @(negedge clk_sys);
    end
    if (t == 3000)
      hang;
    @(negedge clk_sys);
    req_valid = 1'b0;
    if (!w && op != FHC_OP_RDATA) begin
      for (t = 0; t < 50 && cap_cnt == ncap; t++) @(negedge clk_sys);
      if (t == 50)
        hang;
      ncap++;
      // byte mode: high lanes stay released and quiet even for data writes
      chk(cap_kind === kind_of(op) && cap_val === d[7:0] && hi_oe_n === 1'b1 && hi_o === 8'h00, "latched cycle");
    end else begin
      // one idle edge so the next offer never rewrites valid in this step
      @(negedge clk_sys);
    end
  endtask
  // pop one word with random drain stalls
  task automatic pop;
    int t;
    for (t = 0; t < 60; t++) begin
      rd_ready = 1'($random(seed));
      #1;
      if (rd_ready && rd_valid === 1'b1)
        break;
      @(negedge clk_sys);
    end
    if (t == 60)
      hang;
    chk(rd_data === exp_word(nrd), "read word");
    nrd++;
    @(negedge clk_sys);
    rd_ready = 1'b0;
    // let one edge pass so the next pop does not rewrite ready in this step
    @(negedge clk_sys);
  endtask
  initial begin
    seed = 459;
    arst_n = 1'b0;
    req_valid = 1'b0;
    rd_ready = 1'b0;
    wp_release = 1'b0;
    req = '0;
    repeat (5) @(negedge clk_sys);
    chk(pins === PINS_RESET && io_low_byte_oe_n === 1'b1, "reset pins");
    arst_n = 1'b1;
    for (k = 0; k < 3000 && recovered !== 1'b1; k++) @(negedge clk_sys);
    if (k == 3000)
      hang;
    chk(k >= RECOVER_CYC - 2 && k <= RECOVER_CYC + 2, "recovery length");
    $display("test recovery done");
    // command, five address cycles, one data write, all random bytes
    for (i = 0; i < 7; i++) begin
      v = 8'($random(seed));
      send(1'b0, i == 0 ? FHC_OP_CMD : i < 6 ? FHC_OP_ADDR : FHC_OP_WDATA, {v, v});
    end
    $display("test latch cycles done");
    // program start under protect, then with protect released
    send(1'b0, FHC_OP_CMD, {8'h00, OP_CMD});
    repeat (20) @(negedge clk_sys);
    chk(flash_busy === 1'b0, "busy under protect");
    wp_release = 1'b1;
    send(1'b0, FHC_OP_CMD, {8'h00, OP_CMD});
    chk(flash_busy === 1'b1, "not busy");
    send(1'b1, FHC_OP_CMD, '0);
    chk(pins.ce_n === 1'b0, "select dropped while busy");
    for (k = 0; k < 500 && req_ready !== 1'b1; k++) @(negedge clk_sys);
    if (k == 500)
      hang;
    chk(flash_busy === 1'b0 && cap_cnt === ncap, "wait on ready");
    $display("test protect done");
    // reads: fill the fifo while stalled, refuse one more, drain
    send(1'b0, FHC_OP_CMD, 16'h0000);
    for (r = 0; r < 2; r++) begin
      for (i = 0; i < RD_FIFO_DEPTH - 2 * r; i++) send(1'b0, FHC_OP_RDATA, '0);
      if (r == 0) begin
        req_valid = 1'b1;
        repeat (30) @(negedge clk_sys);
        chk(req_ready === 1'b0 && rd_valid === 1'b1, "full fifo took a read");
        req_valid = 1'b0;
      end
      for (i = 0; i < RD_FIFO_DEPTH - 2 * r; i++) pop;
      chk(rd_valid === 1'b0, "fifo not empty");
    end
    $display("test reads done");
    test_done;
  end
endmodule
